// [rtl/adc_error_irq.sv]
// Error and interrupt flag logic of the converter sequencing engine.
// Assumes the flow events come from sequencer logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "adc_error_irq_params.svh"
module adc_error_irq (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire adc_error_irq_pkg::flow_events_type flowEvents,
  input wire adc_error_irq_pkg::flow_mode_type flowMode,
  output logic converterHalt,
  output logic moduleEnable,
  output logic abortDoneIrq,
  output logic flagOverrunIrq
);
  logic [7:0] enableReg, enableNext;
  logic [7:0] errorReg, errorNext;
  logic [7:0] flagReg, flagNext;
  logic [1:0] controlReg, controlNext;
  logic ackReg;
  logic waitReg;
  logic [31:0] readReg, readNext;
  logic haltReg, abortIrqReg, overrunIrqReg;
  logic [7:0] errorSet, flagSet, flowClear, irqClear;

  function automatic logic [7:0] bitAt(input int pos, input logic val);
    bitAt = 8'h00;
    bitAt[pos[2:0]] = val;
  endfunction

  // Access completes one cycle after request, waitrequest low on the ack cycle.
  wire logic access = (avs_read | avs_write) & ~ackReg;
  wire logic writeHit = avs_write & ~ackReg;
  wire logic selEnable = avs_address == `IRQ_ENABLE_INDEX;
  wire logic selError = avs_address == `ERROR_FLAGS_INDEX;
  wire logic selFlag = avs_address == `IRQ_FLAGS_INDEX;
  wire logic selControl = avs_address == `CONTROL_INDEX;
  wire logic enabled = controlReg[`MODULE_ENABLE_BIT];
  wire logic softReset = writeHit & selControl & avs_writedata[`SOFT_RESET_BIT];
  wire adc_error_irq_pkg::flow_events_type ev = flowEvents;
  wire logic restartMode = flowMode == adc_error_irq_pkg::RESTART_MODE;

  wire logic setIllegal = ev.illegalAccess;
  wire logic setCommand = ev.commandValue;
  wire logic setListEnd = ev.listEndMissing;
  wire logic setTrigger = ev.triggerLate | ev.triggerBusy
    | (restartMode & ev.triggerAfterAbort)
    | (~restartMode & (ev.triggerBeforeRestart | ev.triggerCollision));
  wire logic setRestart = ev.earlyRestart & ~ev.restartOverrun;
  wire logic setLoadOk = restartMode & ev.restartNoLoadOk & ~ev.abortActive
    & ~ev.firstRestart & ~ev.singleBuffer;
  // Abort done except low-power and last-command aborts.
  wire logic setAbortDone = ev.abortDone & ~ev.abortForLowPower & ~ev.abortAtLastCommand;
  // Overrun; list end overrun hidden in single buffer.
  wire logic setOverrun = ev.conversionOverrun | (ev.listEndOverrun & ~ev.resultSingleBuffer);

  assign errorSet = bitAt(`ILLEGAL_ACCESS_BIT, setIllegal) | bitAt(`COMMAND_VALUE_BIT, setCommand)
    | bitAt(`LIST_END_BIT, setListEnd) | bitAt(`TRIGGER_BIT, setTrigger)
    | bitAt(`RESTART_REQUEST_BIT, setRestart) | bitAt(`LOAD_OK_BIT, setLoadOk);
  assign flagSet = bitAt(`ABORT_DONE_BIT, setAbortDone) | bitAt(`FLAG_OVERRUN_BIT, setOverrun);
  // Only ones written to flow bits clear them.
  assign flowClear = (writeHit & selError) ? (avs_writedata[7:0] & `FLOW_MASK) : 8'h00;
  assign irqClear = (writeHit & selFlag) ? (avs_writedata[7:0] & `IRQ_ENABLE_MASK) : 8'h00;

  always_comb begin
    errorNext = (errorReg & ~flowClear) | errorSet;
    flagNext = (flagReg & ~irqClear) | flagSet;
    // Soft reset clears all error flags.
    if (softReset) begin
      errorNext = 8'h00;
      flagNext = 8'h00;
    end
    if (!enabled) begin
      errorNext = 8'h00;
      flagNext = 8'h00;
    end
  end

  // Enable register stores only the two gate bits.
  assign enableNext = (writeHit & selEnable) ? (avs_writedata[7:0] & `IRQ_ENABLE_MASK) : enableReg;
  assign controlNext = (writeHit & selControl) ? {1'b0, avs_writedata[`MODULE_ENABLE_BIT]}
    : controlReg;
  assign readNext = selEnable ? {24'h000000, enableReg}
    : selError ? {24'h000000, errorReg}
    : selFlag ? {24'h000000, flagReg}
    : selControl ? {30'h00000000, controlReg} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enableReg <= `REG_RESET;
      errorReg <= `REG_RESET;
      flagReg <= `REG_RESET;
      controlReg <= 2'h0;
      ackReg <= 1'b0;
      waitReg <= 1'b1;
      readReg <= 32'h00000000;
    end else begin
      waitReg <= ~access;
      enableReg <= enableNext;
      errorReg <= errorNext;
      flagReg <= flagNext;
      controlReg <= controlNext;
      ackReg <= access;
      readReg <= access ? readNext : readReg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      haltReg <= 1'b0;
      abortIrqReg <= 1'b0;
      overrunIrqReg <= 1'b0;
    end else begin
      haltReg <= |(errorNext & `SEVERE_MASK);
      abortIrqReg <= flagNext[`ABORT_DONE_BIT] & enableNext[`ABORT_DONE_BIT];
      overrunIrqReg <= flagNext[`FLAG_OVERRUN_BIT] & enableNext[`FLAG_OVERRUN_BIT];
    end
  end

  assign avs_readdata = readReg;
  // A flop of its own keeps waitrequest glitch free at the bus.
  assign avs_waitrequest = waitReg;
  assign converterHalt = haltReg;
  assign moduleEnable = controlReg[`MODULE_ENABLE_BIT];
  assign abortDoneIrq = abortIrqReg;
  assign flagOverrunIrq = overrunIrqReg;

  a_halt_on_severe: assert property (@(posedge clk) disable iff (sys_rst)
    |(errorReg & `SEVERE_MASK) |-> converterHalt) else $error("Halt missing.");
  a_severe_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    errorReg[`TRIGGER_BIT] && enabled && !softReset |=> errorReg[`TRIGGER_BIT])
    else $error("Severe flag cleared.");
  a_flow_no_halt: assert property (@(posedge clk) disable iff (sys_rst)
    (errorReg & `SEVERE_MASK) == 8'h00 |-> !converterHalt) else $error("Bad halt.");
  a_disable_clears: assert property (@(posedge clk) disable iff (sys_rst)
    !enabled |=> errorReg == 8'h00 && flagReg == 8'h00) else $error("Flags kept.");
  a_soft_reset: assert property (@(posedge clk) disable iff (sys_rst)
    softReset |=> (errorReg & `SEVERE_MASK) == 8'h00) else $error("Reset ignored.");
  a_write_one_clears: assert property (@(posedge clk) disable iff (sys_rst)
    writeHit && selError && avs_writedata[`LOAD_OK_BIT] && !setLoadOk
    |=> !errorReg[`LOAD_OK_BIT]) else $error("Clear failed.");
  a_no_write_set: assert property (@(posedge clk) disable iff (sys_rst)
    !errorReg[`RESTART_REQUEST_BIT] && !setRestart |=> !errorReg[`RESTART_REQUEST_BIT])
    else $error("Spurious set.");
  a_abort_irq: assert property (@(posedge clk) disable iff (sys_rst)
    abortDoneIrq == (flagReg[`ABORT_DONE_BIT] & enableReg[`ABORT_DONE_BIT]))
    else $error("Abort irq wrong.");
  a_overrun_irq: assert property (@(posedge clk) disable iff (sys_rst)
    flagOverrunIrq == (flagReg[`FLAG_OVERRUN_BIT] & enableReg[`FLAG_OVERRUN_BIT]))
    else $error("Overrun irq wrong.");
  a_overrun_set: assert property (@(posedge clk) disable iff (sys_rst)
    enabled && !softReset && ev.conversionOverrun && !(writeHit && selControl)
    |=> flagReg[`FLAG_OVERRUN_BIT]) else $error("Overrun lost.");
  a_waitrequest: assert property (@(posedge clk) disable iff (sys_rst)
    access |=> !avs_waitrequest) else $error("No answer.");

  c_halt: cover property (@(posedge clk) $rose(converterHalt));
  c_abort_irq: cover property (@(posedge clk) $rose(abortDoneIrq));
  c_flow_clear: cover property (@(posedge clk) $fell(errorReg[`LOAD_OK_BIT]) && enabled);
  c_soft_reset: cover property (@(posedge clk) softReset && converterHalt);
endmodule
`default_nettype wire

// [shared/adc_error_irq_params.svh]
// Constants for the converter error and interrupt flag block.
// Assumes an Avalon-MM slave with 8-bit registers at word addresses.
// Notes on behaviour
// - Bit 7 enables abort-done interrupt.
// - Bit 6 enables flag-overrun interrupt.
// - Severe error halts all conversion activity.
// - Soft reset clears severe flags, resumes.
// - Restart and load-ok errors never halt.
// - Flow errors clear by write one, reset.
// - All flags cleared while module disabled.
// - Write zero keeps; write one never sets.
// - Severe flags ignore writes; flow flags writable.
// - Bit 7 flags illegal access events.
// - Bit 6 flags invalid loaded commands.
// - Bit 5 flags missing list end.
// - Restart mode trigger ordering errors, bit 3.
// - Trigger mode: trigger before restart errors.
// - Trigger before sequence finish errors.
// - Trigger during trigger processing errors.
// - Hardware trigger colliding with bus trigger; flagged in trigger mode only.
// - Bit 2 flags early restart request.
// - Restart overrun never sets restart error.
// - Load-ok error suppressed after start, single buffer.
// - Bit 7 flags abort done, with exceptions.
// - Bit 6 flags conversion flag overrun.
`ifndef ADC_ERROR_IRQ_PARAMS_SVH
`define ADC_ERROR_IRQ_PARAMS_SVH
`define IRQ_ENABLE_INDEX 8'h07
`define ERROR_FLAGS_INDEX 8'h08
`define IRQ_FLAGS_INDEX 8'h09
`define CONTROL_INDEX 8'h0A
`define ABORT_DONE_BIT 7
`define FLAG_OVERRUN_BIT 6
`define ILLEGAL_ACCESS_BIT 7
`define COMMAND_VALUE_BIT 6
`define LIST_END_BIT 5
`define TRIGGER_BIT 3
`define RESTART_REQUEST_BIT 2
`define LOAD_OK_BIT 1
`define MODULE_ENABLE_BIT 0
`define SOFT_RESET_BIT 1
`define SEVERE_MASK 8'hE8
`define FLOW_MASK 8'h06
`define IRQ_ENABLE_MASK 8'hC0
`define REG_RESET 8'h00
`endif

// [shared/adc_error_irq_pkg.sv]
// Types for the converter error and interrupt flag block.
// Assumes the params header supplies all numeric constants.
package adc_error_irq_pkg;
  typedef struct packed {
    logic illegalAccess;
    logic commandValue;
    logic listEndMissing;
    logic triggerLate;
    logic triggerBeforeRestart;
    logic triggerBusy;
    logic triggerCollision;
    logic triggerAfterAbort;
    logic earlyRestart;
    logic restartOverrun;
    logic restartNoLoadOk;
    logic firstRestart;
    logic singleBuffer;
    logic abortActive;
    logic abortDone;
    logic abortForLowPower;
    logic abortAtLastCommand;
    logic conversionOverrun;
    logic listEndOverrun;
    logic resultSingleBuffer;
  } flow_events_type;
  typedef enum logic {RESTART_MODE, TRIGGER_MODE} flow_mode_type;
endpackage

// [bench/flow_event_model.sv]
// Far-side model: the sequencer's one-cycle flow event pulses.
// Assumes the bench asks for events on the block's clock.
`timescale 1ns/1ps
`default_nettype none
module flow_event_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [19:0] evReq,
  output var adc_error_irq_pkg::flow_events_type flowEvents
);
  // Sequencer event pulses.
  // A held request repeats each cycle, so the bench drops it after one edge.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flowEvents <= '0;
    end else begin
      flowEvents <= adc_error_irq_pkg::flow_events_type'(evReq);
    end
  end
endmodule
`default_nettype wire

// [bench/adc_error_irq_flag_logic_tb.sv]
// Bench for the error and interrupt flag block.
// Assumes the event model on the far side and Avalon access to registers.
`timescale 1ns/1ps
`default_nettype none
module adc_error_irq_flag_logic_tb;
  localparam adc_error_irq_pkg::flow_mode_type RM = adc_error_irq_pkg::RESTART_MODE;
  localparam adc_error_irq_pkg::flow_mode_type TM = adc_error_irq_pkg::TRIGGER_MODE;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic converterHalt, moduleEnable, abortDoneIrq, flagOverrunIrq;
  logic [7:0] avs_address, q;
  logic [31:0] avs_writedata, avs_readdata;
  logic [19:0] evReq;
  adc_error_irq_pkg::flow_events_type flowEvents;
  adc_error_irq_pkg::flow_mode_type flowMode;
  int nMismatch, numChecks;
  flow_event_model model_u (.clk(clk), .sys_rst(sys_rst), .evReq(evReq), .flowEvents(flowEvents));
  adc_error_irq dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flowEvents(flowEvents), .flowMode(flowMode), .converterHalt(converterHalt),
    .moduleEnable(moduleEnable), .abortDoneIrq(abortDoneIrq), .flagOverrunIrq(flagOverrunIrq));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic summarize();
    if (nMismatch == 0 && numChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] s, input logic [7:0] e);
    numChecks++;
    if (s !== e) begin
      nMismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // The request stays up until waitrequest is seen low or 50 cycles pass, so answers within 49 cycles are safe.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      nMismatch++;
      summarize();
    end
  endtask
  task automatic chkReg(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    cmp($sformatf("reg %h", a), q, e);
  endtask
  task automatic fire(input logic [19:0] v);
    @(posedge clk);
    evReq <= v;
    @(posedge clk);
    evReq <= 20'h00000;
    repeat (3) @(posedge clk);
  endtask
  task automatic run(input adc_error_irq_pkg::flow_mode_type m, input logic [19:0] v,
                     input logic [7:0] ef, input logic [7:0] irf);
    flowMode <= m;
    fire(v);
    chkReg(8'h08, ef);
    chkReg(8'h09, irf);
    cmp("halt", {7'h00, converterHalt}, {7'h00, |(ef & 8'hE8)});
    cmp("abort irq", {7'h00, abortDoneIrq}, {7'h00, irf[7]});
    cmp("overrun irq", {7'h00, flagOverrunIrq}, {7'h00, irf[6]});
    acc(1'b1, 8'h0A, 8'h03);
    chkReg(8'h08, 8'h00);
    cmp("halt", {7'h00, converterHalt}, 8'h00);
  endtask
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    evReq = 20'h00000;
    flowMode = RM;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    chkReg(8'h07, 8'h00);
    chkReg(8'h20, 8'h00);
    fire(20'h80000);
    chkReg(8'h08, 8'h00);
    acc(1'b1, 8'h0A, 8'h01);
    cmp("enable", {7'h00, moduleEnable}, 8'h01);
    acc(1'b1, 8'h07, 8'hFF);
    chkReg(8'h07, 8'hC0);
    run(RM, 20'h80000, 8'h80, 8'h00);
    run(RM, 20'h40000, 8'h40, 8'h00);
    run(RM, 20'h20000, 8'h20, 8'h00);
    run(RM, 20'h10000, 8'h08, 8'h00);
    run(TM, 20'h08000, 8'h08, 8'h00);
    run(RM, 20'h08000, 8'h00, 8'h00);
    run(RM, 20'h04000, 8'h08, 8'h00);
    run(TM, 20'h02000, 8'h08, 8'h00);
    run(RM, 20'h02000, 8'h00, 8'h00);
    run(RM, 20'h01000, 8'h08, 8'h00);
    run(TM, 20'h01000, 8'h00, 8'h00);
    run(TM, 20'h00800, 8'h04, 8'h00);
    run(RM, 20'h00C00, 8'h00, 8'h00);
    run(RM, 20'h00200, 8'h02, 8'h00);
    run(TM, 20'h00200, 8'h00, 8'h00);
    run(RM, 20'h00240, 8'h00, 8'h00);
    run(RM, 20'h00300, 8'h00, 8'h00);
    run(RM, 20'h00280, 8'h00, 8'h00);
    run(RM, 20'h00020, 8'h00, 8'h80);
    run(RM, 20'h00030, 8'h00, 8'h00);
    run(RM, 20'h00028, 8'h00, 8'h00);
    run(RM, 20'h00004, 8'h00, 8'h40);
    run(RM, 20'h00002, 8'h00, 8'h40);
    run(RM, 20'h00003, 8'h00, 8'h00);
    fire(20'h10A00);
    acc(1'b1, 8'h08, 8'h00);
    chkReg(8'h08, 8'h0E);
    acc(1'b1, 8'h08, 8'hFF);
    chkReg(8'h08, 8'h08);
    acc(1'b1, 8'h0A, 8'h00);
    chkReg(8'h08, 8'h00);
    acc(1'b1, 8'h0A, 8'h01);
    acc(1'b1, 8'h07, 8'h40);
    fire(20'h00020);
    cmp("abort irq", {7'h00, abortDoneIrq}, 8'h00);
    acc(1'b1, 8'h07, 8'hC0);
    repeat (2) @(posedge clk);
    cmp("abort irq", {7'h00, abortDoneIrq}, 8'h01);
    acc(1'b1, 8'h09, 8'h80);
    chkReg(8'h09, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
